// ==== hw/cpu_shift_unit.sv ====
// arithmetic and logical shift datapath with APB register access
// assumes an APB master on clk_in; no wait states are inserted
//
// The implementer's own choices: register access over APB and the register offsets.
`include "shift_unit_map.svh"
`timescale 1ns/1ps
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
module cpu_shift_unit
  import shift_unit_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        ce_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic      [31:0] result_out,
  output logic      [7:0]  flags_out,
  output logic             busy_out
);
  shift_if sif ();

  logic [31:0] operand_q;
  logic [7:0]  count_q;
  size_t       size_q;
  shift_op_t   op_q;
  count_src_t  src_q;
  logic [7:0]  flags_q;
  logic [7:0]  flags_d;
  logic [31:0] result_q;
  logic        done_q;
  logic        bad_q;
  exec_state_t st_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic        mapped;
  logic        access;
  logic        wr;
  logic [31:0] wmask;
  logic        go;
  logic        run;

  //------------------------------------------------------------
  // datapath
  //------------------------------------------------------------
  assign sif.operand = operand_q;
  assign sif.count   = count_q;
  assign sif.size    = size_q;
  assign sif.op      = op_q;
  assign sif.src     = src_q;

  count_check u_count (
    .sif (sif)
  );

  shift_core u_core (
    .sif (sif)
  );

  //------------------------------------------------------------
  // APB slave
  //------------------------------------------------------------
  assign access = psel_in && penable_in && pready_q;
  assign wr     = access && pwrite_in;

  generate
    for (genvar g = 0; g < 4; g++) begin : g_lane
      assign wmask[g*8 +: 8] = {8{pstrb_in[g]}};
    end
  endgenerate

  always_comb begin
    mapped = 1'b1;
    if (paddr_in == `OFS_CTRL) begin
      rd_mux = {28'h0000_000, src_q, size_q, op_q};
    end else if (paddr_in == `OFS_OPERAND) begin
      rd_mux = operand_q;
    end else if (paddr_in == `OFS_COUNT) begin
      rd_mux = {24'h00_0000, count_q};
    end else if (paddr_in == `OFS_FLAGS) begin
      rd_mux = {24'h00_0000, flags_q};
    end else if (paddr_in == `OFS_RESULT) begin
      rd_mux = result_q;
    end else if (paddr_in == `OFS_STATUS) begin
      rd_mux = {29'h0000_0000, st_q, bad_q, done_q};
    end else begin
      rd_mux = `RST_WORD;
      mapped = 1'b0;
    end
  end

  // answer in the cycle after setup, no wait states
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `RST_WORD;
    end else if (ce_in) begin
      pready_q  <= psel_in && !penable_in;
      pslverr_q <= psel_in && !penable_in && !mapped;
      if (psel_in && !penable_in && !pwrite_in) begin
        prdata_q <= rd_mux;
      end
    end
  end

  assign prdata_out  = prdata_q;
  assign pready_out  = pready_q;
  assign pslverr_out = pslverr_q;

  //------------------------------------------------------------
  // software registers
  //------------------------------------------------------------
  assign go = wr && (paddr_in == `OFS_CTRL) && pstrb_in[1] &&
              pwdata_in[`CTRL_GO] && (st_q == st_idle);
  assign run = (st_q == st_exec) && !sif.bad && !sif.zero;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      op_q   <= logic_shift_op;
      size_q <= sz_byte;
      src_q  <= src_imm;
    end else if (ce_in && wr && paddr_in == `OFS_CTRL &&
                 pstrb_in[0] && st_q == st_idle) begin
      op_q   <= shift_op_t'(pwdata_in[`CTRL_OP]);
      size_q <= size_t'(pwdata_in[`CTRL_SZ_HI:`CTRL_SZ_LO]);
      src_q  <= count_src_t'(pwdata_in[`CTRL_SRC]);
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      operand_q <= `RST_WORD;
    end else if (ce_in && wr && paddr_in == `OFS_OPERAND) begin
      operand_q <= (operand_q & ~wmask) | (pwdata_in & wmask);
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      count_q <= `RST_COUNT;
    end else if (ce_in && wr && paddr_in == `OFS_COUNT &&
                 pstrb_in[0]) begin
      count_q <= pwdata_in[7:0];
    end
  end

  //------------------------------------------------------------
  // execution sequence
  //------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_q <= st_idle;
    end else if (ce_in) begin
      case (st_q)
        st_idle: if (go) st_q <= st_exec;
        st_exec: st_q <= st_idle;
        default: st_q <= st_idle;
      endcase
    end
  end

  always_comb begin
    flags_d = flags_q;
    flags_d[`FLG_C] = sif.carry;
    flags_d[`FLG_S] = sif.sign;
    flags_d[`FLG_Z] = sif.zflag;
    // long z and c are simply computed as usual
    if (op_q == arith_shift_op && size_q != sz_long) begin
      flags_d[`FLG_O] = sif.ovf;
    end
  end

  // hardware update wins over a software write in the same cycle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      flags_q <= `RST_FLAGS;
    end else if (ce_in) begin
      if (run) begin
        flags_q <= flags_d;
      end else if (wr && paddr_in == `OFS_FLAGS && pstrb_in[0]) begin
        flags_q <= pwdata_in[7:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      result_q <= `RST_WORD;
    end else if (ce_in && st_q == st_exec && !sif.bad) begin
      // zero count passes the operand through
      result_q <= sif.zero ? operand_q : sif.result;
    end
  end

  // out of range counts are refused and flagged
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      done_q <= 1'b0;
      bad_q  <= 1'b0;
    end else if (ce_in) begin
      if (st_q == st_exec) begin
        done_q <= 1'b1;
      end else if (wr && paddr_in == `OFS_STATUS && pstrb_in[0] &&
                   pwdata_in[`ST_DONE]) begin
        done_q <= 1'b0;
      end
      if (st_q == st_exec && sif.bad) begin
        bad_q <= 1'b1;
      end else if (wr && paddr_in == `OFS_STATUS && pstrb_in[0] &&
                   pwdata_in[`ST_BAD]) begin
        bad_q <= 1'b0;
      end
    end
  end

  assign result_out = result_q;
  assign flags_out  = flags_q;
  assign busy_out   = st_q;

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  logic        ex;
  logic [31:0] ref_c;
  logic [31:0] ref_w;
  assign ex    = (st_q == st_exec) && ce_in && !sif.bad;
  assign ref_c = sif.left ? (operand_q >> 5'(5'd8 - sif.mag))
                          : (operand_q >> 5'(sif.mag - 5'd1));
  // word carry reference: last bit out at either end
  assign ref_w = sif.left ? (operand_q >> 5'(5'd16 - sif.mag))
                          : (operand_q >> 5'(sif.mag - 5'd1));

  a_zero_count_hold: assert property (ex && sif.zero |=>
    flags_q == $past(flags_q) && result_q == $past(operand_q))
    else $error("zero count changed flags or result");
  a_left_direction: assert property (ex && !sif.zero &&
    sif.left && size_q == sz_byte |=>
    result_q[7:0] == 8'($past(operand_q[7:0]) << $past(sif.mag)))
    else $error("positive count did not shift left");
  a_logic_right_fill: assert property (ex && !sif.zero &&
    !sif.left && op_q == logic_shift_op && size_q == sz_word |=>
    result_q[15:0] == $past(operand_q[15:0]) >> $past(sif.mag))
    else $error("logical right shift fill wrong");
  a_arith_sign_keep: assert property (ex && !sif.zero &&
    !sif.left && op_q == arith_shift_op && size_q == sz_byte |=>
    result_q[7] == $past(operand_q[7]))
    else $error("arithmetic right shift lost sign");
  a_carry_byte_out: assert property (ex && !sif.zero &&
    size_q == sz_byte |=> flags_q[`FLG_C] == $past(ref_c[0]))
    else $error("carry is not the last bit out");
  a_sign_flag_msb: assert property (ex && !sif.zero &&
    size_q == sz_word |=> flags_q[`FLG_S] == result_q[15])
    else $error("sign flag mismatch");
  a_zero_flag_val: assert property (ex && !sif.zero &&
    size_q == sz_byte |=>
    flags_q[`FLG_Z] == (result_q[7:0] == 8'h00))
    else $error("zero flag mismatch");
  a_arith_ovf_msb: assert property (ex && !sif.zero &&
    op_q == arith_shift_op && size_q == sz_byte |=>
    flags_q[`FLG_O] == (result_q[7] != $past(operand_q[7])))
    else $error("overflow flag mismatch");
  a_long_ovf_keep: assert property (ex &&
    op_q == arith_shift_op && size_q == sz_long |=>
    $stable(flags_q[`FLG_O]))
    else $error("long arithmetic shift changed overflow");
  a_ctl_flags_keep: assert property (ex &&
    op_q == logic_shift_op |=> $stable(flags_q[`FLG_O]) &&
    $stable({flags_q[`FLG_U], flags_q[`FLG_I], flags_q[`FLG_B],
             flags_q[`FLG_D]}))
    else $error("logical shift touched reserved flags");
  a_bad_count_flag: assert property (st_q == st_exec && ce_in &&
    sif.bad |=> bad_q && $stable(result_q) && $stable(flags_q))
    else $error("bad count not refused");
  a_reg_byte_limit: assert property (st_q == st_exec &&
    src_q == src_reg && size_q == sz_byte && !sif.bad |->
    sif.mag <= 5'd8)
    else $error("byte count limit wrong");
  a_done_one_cycle: assert property (go && ce_in |=>
    st_q == st_exec ##1 !ce_in || st_q == st_idle)
    else $error("execution did not finish");

  a_right_direction: assert property (ex && !sif.zero &&
    !sif.left && op_q == logic_shift_op && size_q == sz_byte |=>
    result_q[7:0] == $past(operand_q[7:0]) >> $past(sif.mag))
    else $error("negative count did not shift right");
  a_arith_right_fill: assert property (ex && !sif.zero &&
    !sif.left && op_q == arith_shift_op && size_q == sz_word |=>
    result_q[15:0] == 16'($signed($past(operand_q[15:0])) >>>
                          $past(sif.mag)))
    else $error("arithmetic right shift fill wrong");
  a_sign_flag_byte: assert property (ex && !sif.zero &&
    size_q == sz_byte |=> flags_q[`FLG_S] == result_q[7])
    else $error("byte sign flag mismatch");
  a_carry_word_out: assert property (ex && !sif.zero &&
    size_q == sz_word |=> flags_q[`FLG_C] == $past(ref_w[0]))
    else $error("word carry is not the last bit out");
  a_zero_flag_word: assert property (ex && !sif.zero &&
    size_q == sz_word |=>
    flags_q[`FLG_Z] == (result_q[15:0] == 16'h0000))
    else $error("word zero flag mismatch");
  a_word_ovf_msb: assert property (ex && !sif.zero &&
    op_q == arith_shift_op && size_q == sz_word |=>
    flags_q[`FLG_O] == (result_q[15] != $past(operand_q[15])))
    else $error("word overflow flag mismatch");
  a_flags_idle_hold: assert property (!run && !(wr &&
    paddr_in == `OFS_FLAGS) |=> $stable(flags_q))
    else $error("flags moved without a shift or a write");
  a_result_upper_zero: assert property (ex && !sif.zero &&
    size_q == sz_byte |=> result_q[31:8] == 24'h00_0000)
    else $error("byte result not masked");

  c_left_shift: cover property (ex && sif.left && !sif.zero);
  c_right_arith: cover property (ex && !sif.left &&
                                 op_q == arith_shift_op);
  c_zero_count: cover property (ex && sif.zero);
  c_bad_count: cover property (st_q == st_exec && sif.bad);
endmodule

// ==== hw/shift_unit_map.svh ====
// register map, field positions and limits of the shift unit
// assumes an 8-bit APB byte address and 32-bit data
`ifndef SHIFT_UNIT_MAP_SVH
`define SHIFT_UNIT_MAP_SVH
`define OFS_CTRL     8'h00
`define OFS_OPERAND  8'h04
`define OFS_COUNT    8'h08
`define OFS_FLAGS    8'h0c
`define OFS_RESULT   8'h10
`define OFS_STATUS   8'h14
`define CTRL_OP      0
`define CTRL_SZ_LO   1
`define CTRL_SZ_HI   2
`define CTRL_SRC     3
`define CTRL_GO      8
`define FLG_C        0
`define FLG_D        1
`define FLG_Z        2
`define FLG_S        3
`define FLG_B        4
`define FLG_O        5
`define FLG_I        6
`define FLG_U        7
`define ST_DONE      0
`define ST_BAD       1
`define ST_BUSY      2
`define LIM_NARROW   8'h08
`define LIM_WIDE     8'h10
`define MASK_B       32'h0000_00ff
`define MASK_W       32'h0000_ffff
`define MASK_L       32'hffff_ffff
`define RST_WORD     32'h0000_0000
`define RST_FLAGS    8'h00
`define RST_COUNT    8'h00
`endif

// ==== hw/shift_unit_pkg.sv ====
// types shared by the shift unit modules
// assumes nothing beyond the map header
package shift_unit_pkg;
  typedef enum logic [1:0] {
    sz_byte = 2'b00,
    sz_word = 2'b01,
    sz_long = 2'b10,
    sz_rsvd = 2'b11
  } size_t;
  typedef enum logic {
    logic_shift_op = 1'b0,
    arith_shift_op = 1'b1
  } shift_op_t;
  typedef enum logic {
    src_imm = 1'b0,
    src_reg = 1'b1
  } count_src_t;
  typedef enum logic {
    st_idle = 1'b0,
    st_exec = 1'b1
  } exec_state_t;
endpackage

// ==== hw/shift_if.sv ====
// operand, count and result signals between the shift unit modules
// assumes one clock domain; all signals are combinational here
`timescale 1ns/1ps
interface shift_if;
  import shift_unit_pkg::*;
  logic [31:0] operand;
  logic [7:0]  count;
  size_t       size;
  shift_op_t   op;
  count_src_t  src;
  logic [4:0]  mag;
  logic        left;
  logic        zero;
  logic        bad;
  logic [31:0] result;
  logic        carry;
  logic        ovf;
  logic        sign;
  logic        zflag;
  modport ctl  (output operand, count, size, op, src,
                input mag, left, zero, bad, result, carry, ovf, sign,
                zflag);
  modport chk  (input count, size, src, output mag, left, zero, bad);
  modport core (input operand, size, op, mag, left,
                output result, carry, ovf, sign, zflag);
endinterface

// ==== hw/count_check.sv ====
// decodes the signed shift count into direction, distance and validity
// assumes the count is an 8-bit two's complement value
`include "shift_unit_map.svh"
`timescale 1ns/1ps
module count_check
  import shift_unit_pkg::*;
(
  shift_if.chk sif
);
  logic [7:0] abs_v;
  logic [7:0] lim;
  logic       neg;

  always_comb begin
    neg   = sif.count[7];
    abs_v = neg ? 8'(~sif.count + 8'h01) : sif.count;
    // immediates and byte operands stop at eight
    if (sif.src == src_imm || sif.size == sz_byte) begin
      lim = `LIM_NARROW;
    end else begin
      lim = `LIM_WIDE;
    end
    sif.mag  = abs_v[4:0];
    sif.left = ~neg;
    sif.zero = (sif.count == `RST_COUNT);
    sif.bad  = (abs_v > lim) || (sif.size == sz_rsvd) ||
               ((sif.src == src_imm) && sif.zero);
  end
endmodule

// ==== hw/shift_core.sv ====
// combinational shifter and flag generator for byte, word and long
// assumes the distance is 1..16 whenever the result is used
`include "shift_unit_map.svh"
`timescale 1ns/1ps
module shift_core
  import shift_unit_pkg::*;
(
  shift_if.core sif
);
  logic [31:0] mask;
  logic [31:0] val;
  logic [31:0] sext;
  logic [63:0] lft;
  logic [31:0] rsrc;
  logic [31:0] rgt;
  logic [31:0] rbit;
  logic [31:0] res;
  logic        lcarry;
  logic        msb_o;
  logic        msb_r;

  always_comb begin
    case (sif.size)
      sz_byte: mask = `MASK_B;
      sz_word: mask = `MASK_W;
      default: mask = `MASK_L;
    endcase
    val = sif.operand & mask;
    case (sif.size)
      sz_byte: sext = {{24{val[7]}}, val[7:0]};
      sz_word: sext = {{16{val[15]}}, val[15:0]};
      default: sext = val;
    endcase
    // left shifts bring zeros in at the bottom
    lft = {32'h0000_0000, val} << sif.mag;
    // right: sign copies for arithmetic, zeros for logical
    rsrc = (sif.op == arith_shift_op) ? sext : val;
    if (sif.op == arith_shift_op) begin
      rgt = 32'($signed(rsrc) >>> sif.mag);
    end else begin
      rgt = rsrc >> sif.mag;
    end
    rbit = rsrc >> 5'(sif.mag - 5'd1);
    case (sif.size)
      sz_byte: begin
        lcarry = lft[8];
        msb_o  = val[7];
      end
      sz_word: begin
        lcarry = lft[16];
        msb_o  = val[15];
      end
      default: begin
        lcarry = lft[32];
        msb_o  = val[31];
      end
    endcase
    res = (sif.left ? lft[31:0] : rgt) & mask;
    case (sif.size)
      sz_byte: msb_r = res[7];
      sz_word: msb_r = res[15];
      default: msb_r = res[31];
    endcase
    sif.result = res;
    sif.carry  = sif.left ? lcarry : rbit[0];
    sif.sign   = msb_r;
    sif.zflag  = (res == `RST_WORD);
    sif.ovf    = msb_r ^ msb_o;
  end
endmodule

// ==== verification/cpu_shift_unit_test.sv ====
// self-checking bench for the shift unit, driven over its apb port
// assumes the design package and map header are compiled first
`include "shift_unit_map.svh"
`timescale 1ns/1ps
module cpu_shift_unit_test;
  import shift_unit_pkg::*;
  logic              clk;
  logic              srst;
  logic              ce;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic        [7:0] paddr;
  logic       [31:0] pwdata;
  logic        [3:0] strb;
  logic       [31:0] prdata;
  logic              pready;
  logic              pslverr;
  logic       [31:0] res_port;
  logic        [7:0] flg_port;
  logic              busy;
  logic       [31:0] q_rd;
  logic              err_rd;
  logic       [31:0] exp_res;
  int                fail_count;
  int                comparisons;
  int                cyc;
  logic signed [7:0] cnts [10] = '{8'h01, 8'hff, 8'h05, 8'hfb, 8'h08,
                                   8'hf8, 8'h10, 8'hf0, 8'h00, 8'h11};
  logic       [31:0] opds [2]  = '{32'h8000_c3a5, 32'h7f12_3c5a};
  logic        [7:0] flg  [2]  = '{8'ha5, 8'h5a};

  cpu_shift_unit i_dut (
    .clk_in(clk), .srst_in(srst), .ce_in(ce), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(strb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .result_out(res_port),
    .flags_out(flg_port), .busy_out(busy)
  );

  always #20 clk = ~clk;

  //------------------------------------------------------------
  // bus and compare tasks
  //------------------------------------------------------------
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q_rd    = prdata;
    err_rd  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  //------------------------------------------------------------
  // one shift through the registers, with its expected outcome
  //------------------------------------------------------------
  task automatic run_op(input logic op_a, input logic [1:0] sz,
                        input logic src, input logic signed [7:0] c,
                        input logic [31:0] opd, input logic [7:0] f0);
    logic [63:0] x;
    logic [31:0] r;
    logic [7:0]  f;
    logic [7:0]  msk;
    logic        bad;
    int          n;
    int          w;
    int          k;
    n   = (c < 0) ? -c : c;
    w   = (sz == 2'd0) ? 8 : (sz == 2'd1) ? 16 : 32;
    bad = (sz == 2'd3) || (src ? (n > ((sz == 2'd0) ? 8 : 16))
                               : (n == 0 || n > 8));
    f   = f0;
    msk = 8'hff;
    wr(`OFS_FLAGS, {24'h0, f0});
    wr(`OFS_OPERAND, opd);
    wr(`OFS_COUNT, {24'h0, c});
    wr(`OFS_CTRL, {23'h0, 1'b1, 4'h0, src, sz, op_a});
    k    = 0;
    q_rd = 32'h0000_0000;
    while (q_rd[0] !== 1'b1 && k < 20) begin
      rd(`OFS_STATUS);
      k++;
    end
    check(q_rd, {30'h0, bad, 1'b1});
    if (!bad) begin
      x = {32'h0, opd} & ((64'h1 << w) - 64'h1);
      if (n == 0) begin
        r = opd;
      end else begin
        if (c > 0) begin
          f[`FLG_C] = x[w-n];
          x = x << n;
        end else begin
          if (op_a && x[w-1]) x = x | (~64'h0 << w);
          f[`FLG_C] = x[n-1];
          x = x >> n;
        end
        r = x[31:0] & ((w == 32) ? 32'hffff_ffff : (32'h1 << w) - 32'h1);
        f[`FLG_Z] = (r == 32'h0);
        f[`FLG_S] = r[w-1];
        if (op_a && sz != 2'd2) f[`FLG_O] = r[w-1] ^ opd[w-1];
        if (sz == 2'd2) msk = 8'hfa;
      end
      exp_res = r;
    end
    rd(`OFS_RESULT);
    check(q_rd, exp_res);
    check(res_port, exp_res);
    rd(`OFS_FLAGS);
    check(q_rd & {24'h0, msk}, {24'h0, f & msk});
    check({24'h0, flg_port & msk}, {24'h0, f & msk});
    check({31'h0, flg_port[`FLG_C]} & {31'h0, msk[0]},
          {31'h0, f[`FLG_C] & msk[0]});
    wr(`OFS_STATUS, 32'h0000_0003);
  endtask

  //------------------------------------------------------------
  // hang guard
  //------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      give_verdict();
    end
  end

  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial begin
    clk         = 1'b0;
    srst        = 1'b1;
    ce          = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    strb        = 4'hf;
    fail_count  = 0;
    comparisons = 0;
    cyc         = 0;
    exp_res     = 32'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a < 24; a += 4) begin
      rd(a[7:0]);
      check(q_rd, 32'h0000_0000);
    end
    check({23'h0, busy, flg_port}, 32'h0000_0000);
    rd(8'h18);
    check({q_rd[30:0], err_rd}, 32'h0000_0001);
    wr(8'h18, 32'hffff_ffff);
    check({31'h0, err_rd}, 32'h0000_0001);
    wr(`OFS_RESULT, 32'hffff_ffff);
    rd(`OFS_RESULT);
    check(q_rd, 32'h0000_0000);
    strb <= 4'h2;
    wr(`OFS_OPERAND, 32'hffff_ffff);
    strb <= 4'hf;
    rd(`OFS_OPERAND);
    check(q_rd, 32'h0000_ff00);
    // a low clock enable holds the running shift
    wr(`OFS_OPERAND, 32'h0000_0081);
    wr(`OFS_COUNT, 32'h0000_0001);
    wr(`OFS_CTRL, 32'h0000_0100);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    check({31'h0, busy}, 32'h0000_0001);
    check(res_port, 32'h0000_0000);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    exp_res = 32'h0000_0002;
    check({31'h0, busy}, 32'h0000_0000);
    check(res_port, exp_res);
    check({31'h0, flg_port[`FLG_C]}, 32'h0000_0001);
    wr(`OFS_STATUS, 32'h0000_0003);
    // sweep both ops, all four sizes, the ten counts and both count sources
    for (int o = 0; o < 2; o++)
      for (int s = 0; s < 4; s++)
        for (int i = 0; i < 10; i++)
          for (int m = 0; m < 2; m++)
            run_op(o[0], s[1:0], m[0], cnts[i], opds[(i + o) % 2],
                   flg[m]);
    give_verdict();
  end
endmodule
